// file: core/link_override_regs.sv
`timescale 1ns/1ps
`include "link_override_consts.svh"
// What this block does
// - With management polling off, the programmed override modes replace the polled values.
// - Bit 15 picks the automatic source, 0 polling results and 1 integrated PHY outputs.
// - Link state bits 14:13 are 00 automatic, 01 forced up, 10 forced down.
// - Transmit flow control bits 8:7 are 00 automatic, 01 ingress only, 11 egress only.
// - Receive flow control bits 6:5 use the same coding, 10 reserved.
// - Bits 4:0 hold the port PHY address, whose reset value comes from the device address plan.
// - The energy-efficient override replaces the capability passed to the MAC.
// - Energy-efficient bits 1:0 are 00 automatic, 01 forced on, 11 forced off.
// - Ports 1, 2, 3 and 5 have the same override word from f41e on, with no port 4 word.
module link_override_regs
	import link_override_pkg::*;
#(
	parameter int         ADDR_WIDTH   = 18,
	parameter int         EEE_PORTS    = 5,
	parameter logic [4:0] PHY_ADDR_DEF = `PHY_ADDR_RESET
) (
	input  wire logic                  mclk,
	input  wire logic                  resetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_WIDTH-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  polling_enabled,
	input  wire link_info_type         poll_link_info,
	input  wire link_info_type         phy_link_info,
	input  wire logic [EEE_PORTS-1:0]  poll_energy_efficient_capability,
	input  wire logic [EEE_PORTS-1:0]  poll_clock_stop_capable,
	output link_info_type              mac_link_info,
	output logic      [4:0]            phy_address,
	output logic      [EEE_PORTS-1:0]  mac_energy_efficient_capability,
	output logic      [EEE_PORTS-1:0]  mac_clock_stop_capable
);

	////////////////////////////////////////////////////////////////////////////
	// All state of the block
	typedef struct packed {
		logic [31:0]                       prdata;
		logic                              pready;
		logic                              pslverr;
		link_override_type                 link_ovr;
		eee_override_type [EEE_PORTS-1:0]  eee_ovr;
		link_info_type                     mac_link;
		logic [EEE_PORTS-1:0]              eee_cap;
		logic [EEE_PORTS-1:0]              clk_stop;
	} state_type;

	state_type         state;
	state_type         next_state;
	state_type         reset_state;
	reg_select_type    sel;
	logic              access_done;
	logic              access_wait;
	logic [31:0]       read_word;
	link_info_type     auto_info;
	link_info_type     resolved;
	logic [1:0]        link_code;
	logic [1:0]        speed_code;
	logic [1:0]        duplex_code;
	logic [1:0]        tx_fc_code;
	logic [1:0]        rx_fc_code;
	logic              link_up_res;
	logic              full_duplex_res;
	logic [1:0]        speed_res;
	logic [1:0]        tx_flow_res;
	logic [1:0]        rx_flow_res;
	logic [EEE_PORTS-1:0] eee_res;
	logic [EEE_PORTS-1:0] clk_stop_res;

	////////////////////////////////////////////////////////////////////////////
	// Bus address decode
	apb_reg_decode #(
		.ADDR_WIDTH (ADDR_WIDTH)
	) u_decode (
		.paddr (paddr),
		.sel   (sel)
	);

	// A registered answer costs one wait state but keeps the address
	// decode out of the pready path
	// Access phase waits one cycle, then completes on the edge with pready
	assign access_wait = psel & penable & ~state.pready;
	assign access_done = psel & penable & state.pready;

	////////////////////////////////////////////////////////////////////////////
	// Automatic source and effective codes
	// Limitation: the source switch is immediate, so a half-updated
	// polling word can reach the MAC for one cycle
	// automatic source select
	assign auto_info = state.link_ovr.auto_sel ? phy_link_info : poll_link_info;

	// While polling runs every field follows the automatic source
	// overrides only with polling off
	always_comb begin
		link_code   = `CODE_AUTO;
		speed_code  = `SPEED_AUTO;
		duplex_code = `CODE_AUTO;
		tx_fc_code  = `CODE_AUTO;
		rx_fc_code  = `CODE_AUTO;
		if (!polling_enabled) begin
			link_code   = state.link_ovr.link_state_control;
			speed_code  = state.link_ovr.speed;
			duplex_code = state.link_ovr.duplex_control;
			tx_fc_code  = state.link_ovr.transmit_flow_control_mode;
			rx_fc_code  = state.link_ovr.receive_flow_control_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-parameter resolution
	// Reserved codes fall through as automatic instead of holding the
	// old value, so a bad write can never freeze the link picture
	// link forced up or down; reserved 11 stays automatic
	override_resolve #(
		.W        (1),
		.ON_CODE  (`LINK_FORCE_UP),
		.ON_VAL   (1'b1),
		.OFF_CODE (`LINK_FORCE_DOWN),
		.OFF_VAL  (1'b0)
	) u_link (
		.code       (link_code),
		.auto_value (auto_info.link_up),
		.result     (link_up_res)
	);

	// a stray 10 is not trusted; it leaves the duplex automatic
	override_resolve #(
		.W        (1),
		.ON_CODE  (`CODE_ON),
		.ON_VAL   (1'b1),
		.OFF_CODE (`CODE_OFF),
		.OFF_VAL  (1'b0)
	) u_duplex (
		.code       (duplex_code),
		.auto_value (auto_info.full_duplex),
		.result     (full_duplex_res)
	);

	override_resolve #(
		.W        (2),
		.ON_CODE  (`CODE_ON),
		.ON_VAL   (`FC_INGRESS_ONLY),
		.OFF_CODE (`CODE_OFF),
		.OFF_VAL  (`FC_EGRESS_ONLY)
	) u_tx_fc (
		.code       (tx_fc_code),
		.auto_value (auto_info.tx_flow),
		.result     (tx_flow_res)
	);

	override_resolve #(
		.W        (2),
		.ON_CODE  (`CODE_ON),
		.ON_VAL   (`FC_INGRESS_ONLY),
		.OFF_CODE (`CODE_OFF),
		.OFF_VAL  (`FC_EGRESS_ONLY)
	) u_rx_fc (
		.code       (rx_fc_code),
		.auto_value (auto_info.rx_flow),
		.result     (rx_flow_res)
	);

	// speed code is the rate itself unless automatic
	assign speed_res = (speed_code == `SPEED_AUTO) ? auto_info.speed : speed_code;

	// One driver for the whole picture, so no field can be left undriven
	always_comb begin
		resolved             = auto_info;
		resolved.link_up     = link_up_res;
		resolved.speed       = speed_res;
		resolved.full_duplex = full_duplex_res;
		resolved.tx_flow     = tx_flow_res;
		resolved.rx_flow     = rx_flow_res;
	end

	////////////////////////////////////////////////////////////////////////////
	// Energy-efficient capability per port entry
	// Entries run port 0, 1, 2, 3, 5; port 4 has no entry
	// Hazard: entry 4 is port 5, so entry number is not port number
	// for anything wired to these vectors
	for (genvar i = 0; i < EEE_PORTS; i++) begin : g_eee
		override_resolve #(
			.W        (1),
			.ON_CODE  (`CODE_ON),
			.ON_VAL   (1'b1),
			.OFF_CODE (`CODE_OFF),
			.OFF_VAL  (1'b0)
		) u_clk_stop (
			.code       (state.eee_ovr[i].clock_stop_capability),
			.auto_value (poll_clock_stop_capable[i]),
			.result     (clk_stop_res[i])
		);

		override_resolve #(
			.W        (1),
			.ON_CODE  (`CODE_ON),
			.ON_VAL   (1'b1),
			.OFF_CODE (`CODE_OFF),
			.OFF_VAL  (1'b0)
		) u_eee (
			.code       (state.eee_ovr[i].energy_efficient_capability),
			.auto_value (poll_energy_efficient_capability[i]),
			.result     (eee_res[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Read multiplexer; unused upper bits read as zero
	// Reads have no side effects, so a repeated read is always safe
	always_comb begin
		read_word = 32'h0000_0000;
		unique case (sel)
			SEL_LINK: begin
				read_word[`LINK_WORD_BITS] = state.link_ovr;
			end
			SEL_EEE0: begin
				read_word[`EEE_WORD_BITS] = state.eee_ovr[0];
			end
			SEL_EEE1: begin
				read_word[`EEE_WORD_BITS] = state.eee_ovr[1];
			end
			SEL_EEE2: begin
				read_word[`EEE_WORD_BITS] = state.eee_ovr[2];
			end
			SEL_EEE3: begin
				read_word[`EEE_WORD_BITS] = state.eee_ovr[3];
			end
			SEL_EEE5: begin
				read_word[`EEE_WORD_BITS] = state.eee_ovr[4];
			end
			// Live view of what the MAC is being told
			SEL_STATUS: begin
				read_word[`STATUS_INFO_BITS] = state.mac_link;
				read_word[`STATUS_POLL_BIT]  = polling_enabled;
			end
			SEL_NONE: begin
				read_word = 32'h0000_0000;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Reset image
	// Every override word comes back to automatic behaviour
	// address comes from the device plan, a parameter here
	always_comb begin
		reset_state                   = '0;
		reset_state.link_ovr          = `LINK_OVR_RESET;
		reset_state.link_ovr.phy_addr = PHY_ADDR_DEF;
		for (int k = 0; k < EEE_PORTS; k++) begin
			reset_state.eee_ovr[k] = `EEE_OVR_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		next_state          = state;
		next_state.pready   = access_wait;
		next_state.prdata   = 32'h0000_0000;
		next_state.pslverr  = 1'b0;
		// pready lasts one cycle: the wait cycle raises it and its own
		// high level blocks a second answer to the same transfer
		// Read data and error are prepared in the wait cycle
		if (access_wait) begin
			next_state.prdata  = pwrite ? 32'h0000_0000 : read_word;
			next_state.pslverr = (sel == SEL_NONE);
		end
		// Writes land only on the completing edge
		if (access_done && pwrite) begin
			unique case (sel)
				SEL_LINK: begin
					next_state.link_ovr = pwdata[`LINK_WORD_BITS];
				end
				SEL_EEE0: begin
					next_state.eee_ovr[0] = pwdata[`EEE_WORD_BITS];
				end
				SEL_EEE1: begin
					next_state.eee_ovr[1] = pwdata[`EEE_WORD_BITS];
				end
				SEL_EEE2: begin
					next_state.eee_ovr[2] = pwdata[`EEE_WORD_BITS];
				end
				SEL_EEE3: begin
					next_state.eee_ovr[3] = pwdata[`EEE_WORD_BITS];
				end
				SEL_EEE5: begin
					next_state.eee_ovr[4] = pwdata[`EEE_WORD_BITS];
				end
				// Status is read only and misses change nothing
				SEL_STATUS, SEL_NONE: begin
					next_state.link_ovr = state.link_ovr;
				end
			endcase
		end
		// MAC sees forced or automatic values
		next_state.mac_link = resolved;
		next_state.eee_cap  = eee_res;
		next_state.clk_stop = clk_stop_res;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register, synchronous reset
	// Reset on the clock keeps every flop in one domain, with no
	// release timing of its own to close
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state <= reset_state;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	// Trade-off: one cycle of latency on every parameter for clean timing
	assign prdata                 = state.prdata;
	assign pready                 = state.pready;
	assign pslverr                = state.pslverr;
	assign mac_link_info          = state.mac_link;
	// address handed to the polling logic
	assign phy_address            = state.link_ovr.phy_addr;
	assign mac_energy_efficient_capability        = state.eee_cap;
	assign mac_clock_stop_capable = state.clk_stop;

endmodule

// file: core/link_override_consts.svh
`ifndef LINK_OVERRIDE_CONSTS_SVH
`define LINK_OVERRIDE_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices; byte address is four times the index
`define LINK_OVR_INDEX      16'hf410
`define EEE_OVR_P0_INDEX    16'hf41d
`define EEE_OVR_P1_INDEX    16'hf41e
`define EEE_OVR_P2_INDEX    16'hf41f
`define EEE_OVR_P3_INDEX    16'hf420
`define EEE_OVR_P5_INDEX    16'hf422
`define LINK_STATUS_INDEX   16'hf42f

// Word alignment of the byte address
`define ADDR_LSB            2
`define ADDR_ALIGN          2'h0

// Bit spans of each word on the 32-bit bus
`define LINK_WORD_BITS      15:0
`define EEE_WORD_BITS       3:0
`define STATUS_INFO_BITS    7:0
`define STATUS_POLL_BIT     8

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define LINK_OVR_RESET      16'h1805
`define EEE_OVR_RESET       4'h0
`define PHY_ADDR_RESET      5'h05

////////////////////////////////////////////////////////////////////////////////
// Field codes
`define CODE_AUTO           2'h0
`define CODE_ON             2'h1
`define CODE_OFF            2'h3
`define LINK_FORCE_UP       2'h1
`define LINK_FORCE_DOWN     2'h2
`define SPEED_AUTO          2'h3
`define FC_INGRESS_ONLY     2'h2
`define FC_EGRESS_ONLY      2'h1

`endif

// file: core/link_override_pkg.sv
package link_override_pkg;

	// Override word of the port, msb first
	typedef struct packed {
		logic       auto_sel;
		logic [1:0] link_state_control;
		logic [1:0] speed;
		logic [1:0] duplex_control;
		logic [1:0] transmit_flow_control_mode;
		logic [1:0] receive_flow_control_mode;
		logic [4:0] phy_addr;
	} link_override_type;

	// Per-port energy-efficient override word
	typedef struct packed {
		logic [1:0] clock_stop_capability;
		logic [1:0] energy_efficient_capability;
	} eee_override_type;

	// Resolved link parameters; flow control is {ingress, egress}
	typedef struct packed {
		logic       link_up;
		logic [1:0] speed;
		logic       full_duplex;
		logic [1:0] tx_flow;
		logic [1:0] rx_flow;
	} link_info_type;

	// Register selected by the bus address
	typedef enum logic [2:0] {
		SEL_NONE   = 3'b000,
		SEL_LINK   = 3'b001,
		SEL_EEE0   = 3'b010,
		SEL_EEE1   = 3'b011,
		SEL_EEE2   = 3'b100,
		SEL_EEE3   = 3'b101,
		SEL_EEE5   = 3'b110,
		SEL_STATUS = 3'b111
	} reg_select_type;

endpackage

// file: core/override_resolve.sv
`timescale 1ns/1ps
// Picks a forced value or the automatic one from a two-bit control code
module override_resolve
	import link_override_pkg::*;
#(
	parameter int         W        = 1,
	parameter logic [1:0] ON_CODE  = 2'h1,
	parameter logic [W-1:0] ON_VAL = '1,
	parameter logic [1:0] OFF_CODE = 2'h3,
	parameter logic [W-1:0] OFF_VAL = '0
) (
	input  wire logic [1:0]   code,
	input  wire logic [W-1:0] auto_value,
	output logic      [W-1:0] result
);

	// Any code other than the two forces, reserved included, stays automatic
	always_comb begin
		result = auto_value;
		if (code == ON_CODE) begin
			result = ON_VAL;
		end else if (code == OFF_CODE) begin
			result = OFF_VAL;
		end
	end

endmodule

// file: core/apb_reg_decode.sv
`timescale 1ns/1ps
`include "link_override_consts.svh"
// Maps an aligned byte address onto the register it selects
module apb_reg_decode
	import link_override_pkg::*;
#(
	parameter int ADDR_WIDTH = 18
) (
	input  wire logic [ADDR_WIDTH-1:0] paddr,
	output reg_select_type             sel
);

	logic [15:0] index;

	// Index is the word address; unaligned bytes never match
	assign index = 16'(paddr[ADDR_WIDTH-1:`ADDR_LSB]);

	// Port 4 has no word, so its slot falls through as a miss
	always_comb begin
		sel = SEL_NONE;
		if (paddr[`ADDR_LSB-1:0] == `ADDR_ALIGN) begin
			unique case (index)
				`LINK_OVR_INDEX:    sel = SEL_LINK;
				`EEE_OVR_P0_INDEX:  sel = SEL_EEE0;
				`EEE_OVR_P1_INDEX:  sel = SEL_EEE1;
				`EEE_OVR_P2_INDEX:  sel = SEL_EEE2;
				`EEE_OVR_P3_INDEX:  sel = SEL_EEE3;
				`EEE_OVR_P5_INDEX:  sel = SEL_EEE5;
				`LINK_STATUS_INDEX: sel = SEL_STATUS;
				default:            sel = SEL_NONE;
			endcase
		end
	end

endmodule

// file: testbench/link_override_regs_sva.sv
`timescale 1ns/1ps
`include "link_override_consts.svh"
module link_override_regs_sva
	import link_override_pkg::*;
#(
	parameter int         ADDR_WIDTH   = 18,
	parameter logic [4:0] PHY_ADDR_DEF = 5'h05
) (
	input wire logic                  mclk,
	input wire logic                  resetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  polling_enabled,
	input wire link_info_type         poll_link_info,
	input wire link_info_type         phy_link_info,
	input wire link_info_type         mac_link_info,
	input wire logic [4:0]            phy_address
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	// Bus phases of one transfer
	sequence setup_s; psel && !penable; endsequence
	sequence link_write_s; psel && penable && pready && pwrite && paddr == {`LINK_OVR_INDEX, 2'h0};
	endsequence

	////////////////////////////////////////
	AST_ONE_WAIT: assert property (setup_s |=> !pready ##1 pready)
		else $error("answer not in second access cycle");
	AST_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_ERR_DATA: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without answer or with data");
	AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	AST_UNALIGNED: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("unaligned access not refused");
	// Port 4 has no energy-efficient word
	AST_PORT4_HOLE: assert property (pready && paddr == {16'hf421, 2'h0} |-> pslverr)
		else $error("port 4 slot not refused");
	AST_PHY_ADDR: assert property (link_write_s |=> phy_address == $past(pwdata[4:0]))
		else $error("phy address not taken from write");
	// Reset values are checked with reset itself as the trigger
	AST_RESET_VAL: assert property (disable iff (1'b0) !resetn |=>
		phy_address == PHY_ADDR_DEF && !pready && mac_link_info == 8'h00)
		else $error("wrong value under reset");
	AST_POLL_AUTO: assert property (polling_enabled [*2] |->
		mac_link_info == $past(poll_link_info) || mac_link_info == $past(phy_link_info))
		else $error("polling on but output not automatic");
	AST_LINK_FORCE: assert property (
		link_write_s ##0 (pwdata[14] ^ pwdata[13]) ##1 !polling_enabled [*2] |->
		mac_link_info.link_up == $past(pwdata[13], 2))
		else $error("forced link state not shown");
endmodule

bind link_override_regs link_override_regs_sva #(
	.ADDR_WIDTH(ADDR_WIDTH),
	.PHY_ADDR_DEF(PHY_ADDR_DEF)
) link_override_regs_sva_inst (
	.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .polling_enabled, .poll_link_info, .phy_link_info, .mac_link_info,
	.phy_address
);

// file: testbench/link_peer_model.sv
`timescale 1ns/1ps
module link_peer_model
	import link_override_pkg::*;
(
	input wire logic  swap,
	output link_info_type poll_link_info,
	output link_info_type phy_link_info,
	output logic [4:0] poll_energy_efficient_capability,
	output logic [4:0] poll_clock_stop_capable
);
	// The two sources differ in every bit so a wrong pick shows at once
	assign poll_link_info = swap ? 8'h4c : 8'hb3;
	assign phy_link_info = ~poll_link_info;
	// Capability bits flip with swap; limitation: no slow or partial updates
	assign poll_energy_efficient_capability = swap ? 5'h0a : 5'h15;
	assign poll_clock_stop_capable = ~poll_energy_efficient_capability;
endmodule

// file: testbench/port_link_mode_override_regs_bench.sv
`timescale 1ns/1ps
`include "link_override_consts.svh"
module port_link_mode_override_regs_bench
	import link_override_pkg::*;
;
	logic          mclk, resetn, psel, penable, pwrite, polling_enabled, swap, err;
	logic [17:0]   paddr;
	logic [31:0]   pwdata, prdata, rd;
	logic          pready, pslverr;
	link_info_type poll_link_info, phy_link_info, mac_link_info;
	logic [4:0]    phy_address, poll_energy_efficient_capability, poll_clock_stop_capable;
	logic [4:0]    mac_energy_efficient_capability, mac_clock_stop_capable;
	logic [1:0]    k, e, c;
	logic [15:0]   w;
	link_info_type want;
	logic [15:0]   eidx [5] = '{`EEE_OVR_P0_INDEX, `EEE_OVR_P1_INDEX, `EEE_OVR_P2_INDEX,
		`EEE_OVR_P3_INDEX, `EEE_OVR_P5_INDEX};
	int            n_errors = 0;
	int            n_compared = 0;

	link_override_regs link_override_regs_inst (
		.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .polling_enabled, .poll_link_info, .phy_link_info, .poll_energy_efficient_capability,
		.poll_clock_stop_capable, .mac_link_info, .phy_address, .mac_energy_efficient_capability,
		.mac_clock_stop_capable);
	link_peer_model link_peer_model_inst (
		.swap, .poll_link_info, .phy_link_info, .poll_energy_efficient_capability, .poll_clock_stop_capable);

	initial begin
		mclk = 0;
		forever #10 mclk = ~mclk;
	end

	////////////////////////////////////////
	task results;
		if (n_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, g);
		end
	endtask

	// One APB transfer; request held until pready is seen at a rising edge
	task xfer(input logic wr, input logic [17:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	// Expected MAC picture from the override word and both sources
	function automatic link_info_type exp_link(logic [15:0] v, logic pe, link_info_type pl,
		link_info_type ph);
		link_override_type o;
		link_info_type r;
		o = v;
		r = o.auto_sel ? ph : pl;
		if (!pe) begin
			if (o.link_state_control == 2'h1) r.link_up = 1;
			if (o.link_state_control == 2'h2) r.link_up = 0;
			if (o.speed != 2'h3) r.speed = o.speed;
			if (o.duplex_control == 2'h1) r.full_duplex = 1;
			if (o.duplex_control == 2'h3) r.full_duplex = 0;
			if (o.transmit_flow_control_mode == 2'h1) r.tx_flow = 2'h2;
			if (o.transmit_flow_control_mode == 2'h3) r.tx_flow = 2'h1;
			if (o.receive_flow_control_mode == 2'h1) r.rx_flow = 2'h2;
			if (o.receive_flow_control_mode == 2'h3) r.rx_flow = 2'h1;
		end
		return r;
	endfunction

	function automatic logic cap(logic [1:0] code, logic a);
		return code == 2'h1 ? 1'b1 : code == 2'h3 ? 1'b0 : a;
	endfunction

	////////////////////////////////////////
	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata, swap} = '0;
		polling_enabled = 1;
		repeat (2) @(posedge mclk);
		resetn <= 1;
		xfer(0, {`LINK_OVR_INDEX, 2'h0}, 0);
		chk("link_word", `LINK_OVR_RESET, rd);
		chk("phy_address", `PHY_ADDR_RESET, phy_address);
		chk("mac_link_info", poll_link_info, mac_link_info);
		for (int p = 0; p < 5; p++) begin
			xfer(0, {eidx[p], 2'h0}, 0);
			chk("eee_word", 0, rd);
		end
		// Missing port 4 slot and a misaligned address are refused
		xfer(0, {16'hf421, 2'h0}, 0);
		chk("hole_err", 1, err);
		xfer(0, {`LINK_OVR_INDEX, 2'h2}, 0);
		chk("unaligned_err", 1, err);
		// Every non-reserved code of every field, both automatic sources, polling off
		polling_enabled <= 0;
		for (int i = 0; i < 4; i++) begin
			k = i;
			w = {k[0], k == 2'h3 ? 2'h0 : k, k, {3{k == 2'h2 ? 2'h3 : k}}, 5'(i * 7 + 1)};
			swap <= k[0];
			xfer(1, {`LINK_OVR_INDEX, 2'h0}, {16'h0, w});
			repeat (2) @(negedge mclk);
			want = exp_link(w, 0, poll_link_info, phy_link_info);
			chk("mac_link_info", want, mac_link_info);
			chk("phy_address", w[4:0], phy_address);
			xfer(0, {`LINK_OVR_INDEX, 2'h0}, 0);
			chk("link_word", w, rd);
			chk("link_err", 0, err);
		end
		// With polling back on the forced codes stop counting
		polling_enabled <= 1;
		repeat (3) @(negedge mclk);
		want = exp_link(w, 1, poll_link_info, phy_link_info);
		chk("mac_link_info", want, mac_link_info);
		for (int p = 0; p < 5; p++) begin
			e = p;
			c = p + 1;
			xfer(1, {eidx[p], 2'h0}, {28'h0, c, e});
		end
		repeat (2) @(negedge mclk);
		for (int p = 0; p < 5; p++) begin
			e = p;
			c = p + 1;
			chk("mac_eee", cap(e, poll_energy_efficient_capability[p]), mac_energy_efficient_capability[p]);
			chk("mac_clk_stop", cap(c, poll_clock_stop_capable[p]), mac_clock_stop_capable[p]);
			xfer(0, {eidx[p], 2'h0}, 0);
			chk("eee_word", {c, e}, rd);
		end
		results;
	end

	// Hang guard, well past the expected run length
	initial begin
		#(20 * 4000);
		n_errors++;
		results;
	end
endmodule
